// ===== rtl/sid_pkg.sv
// Constants and types for the safety input diagnostics block
//
// Contract
// RQ1 - Read each input on two channels, compare
// RQ2 - High only when both channels High
// RQ3 - Cyclically test High threshold, alarm on fail
// RQ4 - Test switch-to-Low, not pulse-only group
// RQ5 - Two pulse outputs with distinct signatures
// RQ6 - High input must carry assigned signature
// RQ7 - Alternating pulses expose cross-shorts
// RQ8 - Signature check only where pulse assigned
// RQ9 - Multi-contact sensor is AND of contacts
// RQ10 - Two NC contacts: High when both closed
// RQ11 - NO plus NC: NO actuated, NC released
// RQ12 - Time-out: valid combination within window
// RQ13 - Alarm if undefined longer than window
// RQ14 - Start test: pass Low after power-up
// RQ15 - Single-channel pulsed sensor needs assignment
// RQ16 - Latch alarm as flag, hold inputs Low
// RQ17 - Per-input parameters held in registers
package sid_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_IN = 8;
    localparam int NUM_PAIR = NUM_IN / 2;
    localparam int SIG_W = 8;
    localparam logic [NUM_IN-1:0] PULSE_ONLY_INPUT_GROUP = 8'hf0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TIMEOUT_MS = 500;
    localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int TEST_PERIOD_CYC = 256;
    localparam int SETTLE_CYC = 4;
    localparam int CNT_W = 24;
    localparam int TST_W = 8;

    // ------------------------------------------------------------
    // Signatures driven by the two pulse outputs
    // ------------------------------------------------------------
    localparam logic [SIG_W-1:0] SIG_FIRST = 8'hc3;
    localparam logic [SIG_W-1:0] SIG_SECOND = 8'h3c;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [5:0] A_XS_EN = 6'h00;
    localparam logic [5:0] A_PULSE_SEL = 6'h04;
    localparam logic [5:0] A_PAIR_MODE = 6'h08;
    localparam logic [5:0] A_TO_EN = 6'h0c;
    localparam logic [5:0] A_START_EN = 6'h10;
    localparam logic [5:0] A_STATE = 6'h14;
    localparam logic [5:0] A_IRQ_STAT = 6'h18;
    localparam logic [5:0] A_IRQ_MASK = 6'h1c;
    localparam logic [5:0] A_ALARM_CLR = 6'h20;

    // Pair mode: 0 none, 1 two NC, 2 NO plus NC
    localparam logic [1:0] PM_SINGLE = 2'h0;
    localparam logic [1:0] PM_NC_NC = 2'h1;
    localparam logic [1:0] PM_NO_NC = 2'h2;

    // Status bit positions
    localparam int ST_THRESH = 0;
    localparam int ST_LOWTEST = 1;
    localparam int ST_XSHORT = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_W = 4;

    typedef enum logic [1:0] {
        TS_IDLE,
        TS_THRESH,
        TS_LOW
    } sid_test_e;

endpackage

// ===== rtl/sid_sync.sv
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sid_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    // Two flip-flops, first read only by the second
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end
    assign q_o = s2_r;
endmodule
`default_nettype wire

// ===== rtl/sid_pulse_gen.sv
// Pulse output generator stamping two distinct signatures
`timescale 1ns/1ps
`default_nettype none
module sid_pulse_gen
    import sid_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Pulse outputs and signature phase
    output logic pulse_output_first_o,
    output logic pulse_output_second_o,
    output logic [2:0] phase_o
);
    logic [2:0] ph_r;
    logic [2:0] ph_nxt;
    logic p1_r;
    logic p1_nxt;
    logic p2_r;
    logic p2_nxt;

    // Step through signature bits
    always_comb begin
        ph_nxt = ph_r + 3'h1;
        p1_nxt = SIG_FIRST[ph_nxt]; // [RQ5]
        p2_nxt = SIG_SECOND[ph_nxt]; // [RQ5]
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ph_r <= 3'h0;
            p1_r <= 1'b0;
            p2_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            p1_r <= p1_nxt;
            p2_r <= p2_nxt;
        end
    end
    assign pulse_output_first_o = p1_r;
    assign pulse_output_second_o = p2_r;
    assign phase_o = ph_r;
endmodule
`default_nettype wire

// ===== rtl/sid_top.sv
// Safety input diagnostics with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module sid_top
    import sid_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Field inputs, two channels each
    input wire logic [NUM_IN-1:0] in_ch_a_i,
    input wire logic [NUM_IN-1:0] in_ch_b_i,
    // Channel test injection and comparator threshold result
    input wire logic [1:0] thresh_ok_i,
    output logic test_low_o,
    output logic test_thresh_o,
    // Pulse outputs
    output logic pulse_output_first_o,
    output logic pulse_output_second_o,
    // Results
    output logic [NUM_IN-1:0] safe_state_o,
    output logic alarm_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // Synchronisers and pulse generator
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] ch_a;
    logic [NUM_IN-1:0] ch_b;
    logic [1:0] thr_ok;
    logic p1;
    logic p2;
    logic [2:0] phase;

    sid_sync #(.W(NUM_IN)) u_sync_a (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .d_i(in_ch_a_i), .q_o(ch_a)
    ); // [RQ1]
    sid_sync #(.W(NUM_IN)) u_sync_b (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .d_i(in_ch_b_i), .q_o(ch_b)
    ); // [RQ1]
    sid_sync #(.W(2)) u_sync_t (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .d_i(thresh_ok_i), .q_o(thr_ok)
    );
    sid_pulse_gen u_pulse (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .pulse_output_first_o(p1), .pulse_output_second_o(p2),
        .phase_o(phase)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] xs_en_r, xs_en_nxt;
    logic [NUM_IN-1:0] psel_r, psel_nxt;
    logic [2*NUM_PAIR-1:0] pmode_r, pmode_nxt;
    logic [NUM_PAIR-1:0] to_en_r, to_en_nxt;
    logic [NUM_IN-1:0] st_en_r, st_en_nxt;
    logic [ST_W-1:0] stat_r, stat_nxt;
    logic [ST_W-1:0] mask_r, mask_nxt;
    logic alarm_r, alarm_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic irq_r, irq_nxt;
    logic [ST_W-1:0] ev;
    logic alarm_clr;
    logic [NUM_IN-1:0] safe_w;

    // Bus decode: one wait cycle, answer on second cycle
    always_comb begin
        xs_en_nxt = xs_en_r;
        psel_nxt = psel_r;
        pmode_nxt = pmode_r;
        to_en_nxt = to_en_r;
        st_en_nxt = st_en_r;
        mask_nxt = mask_r;
        rdata_nxt = rdata_r;
        alarm_clr = 1'b0;
        stat_nxt = stat_r;
        wait_nxt = 1'b1;
        if ((avs_read_i || avs_write_i) && wait_r) begin
            wait_nxt = 1'b0;
        end
        if (avs_write_i && !wait_r) begin
            case (avs_address_i) // [RQ17]
                A_XS_EN: xs_en_nxt = avs_writedata_i[NUM_IN-1:0];
                A_PULSE_SEL: psel_nxt = avs_writedata_i[NUM_IN-1:0];
                A_PAIR_MODE: pmode_nxt = avs_writedata_i[2*NUM_PAIR-1:0];
                A_TO_EN: to_en_nxt = avs_writedata_i[NUM_PAIR-1:0];
                A_START_EN: st_en_nxt = avs_writedata_i[NUM_IN-1:0];
                A_IRQ_STAT: stat_nxt = stat_r & ~avs_writedata_i[ST_W-1:0];
                A_IRQ_MASK: mask_nxt = avs_writedata_i[ST_W-1:0];
                A_ALARM_CLR: alarm_clr = avs_writedata_i[0];
                default: ;
            endcase
        end
        stat_nxt = stat_nxt | ev; // Set wins over clear
        if (avs_read_i && wait_r) begin
            case (avs_address_i)
                A_XS_EN: rdata_nxt = {24'h0, xs_en_r};
                A_PULSE_SEL: rdata_nxt = {24'h0, psel_r};
                A_PAIR_MODE: rdata_nxt = {24'h0, pmode_r};
                A_TO_EN: rdata_nxt = {28'h0, to_en_r};
                A_START_EN: rdata_nxt = {24'h0, st_en_r};
                A_STATE: rdata_nxt = {23'h0, alarm_r, safe_w};
                A_IRQ_STAT: rdata_nxt = {28'h0, stat_r};
                A_IRQ_MASK: rdata_nxt = {28'h0, mask_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
        alarm_nxt = (alarm_r && !alarm_clr) || (|ev); // [RQ16]
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            xs_en_r <= '0;
            psel_r <= '0;
            pmode_r <= '0;
            to_en_r <= '0;
            st_en_r <= '0;
            stat_r <= '0;
            mask_r <= '0;
            alarm_r <= 1'b0;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            xs_en_r <= xs_en_nxt;
            psel_r <= psel_nxt;
            pmode_r <= pmode_nxt;
            to_en_r <= to_en_nxt;
            st_en_r <= st_en_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            alarm_r <= alarm_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Cyclic channel tests
    // ------------------------------------------------------------
    sid_test_e ts_r, ts_nxt;
    logic [TST_W-1:0] tc_r, tc_nxt;
    logic thr_fail, low_fail;

    // Period, then threshold test, then Low switch test
    always_comb begin
        ts_nxt = ts_r;
        tc_nxt = tc_r + 8'h1;
        thr_fail = 1'b0;
        low_fail = 1'b0;
        case (ts_r)
            TS_IDLE: begin
                if (tc_r == 8'(TEST_PERIOD_CYC - 1)) begin
                    ts_nxt = TS_THRESH;
                    tc_nxt = 8'h0;
                end
            end
            TS_THRESH: begin
                if (tc_r == 8'(SETTLE_CYC - 1)) begin
                    thr_fail = ~&thr_ok; // [RQ3]
                    ts_nxt = TS_LOW;
                    tc_nxt = 8'h0;
                end
            end
            TS_LOW: begin
                if (tc_r == 8'(SETTLE_CYC - 1)) begin
                    // Injected Low must pull every tested path down
                    low_fail = |((ch_a | ch_b) & ~PULSE_ONLY_INPUT_GROUP); // [RQ4]
                    ts_nxt = TS_IDLE;
                    tc_nxt = 8'h0;
                end
            end
            default: begin
                ts_nxt = TS_IDLE;
                tc_nxt = 8'h0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ts_r <= TS_IDLE;
            tc_r <= 8'h0;
        end else begin
            ts_r <= ts_nxt;
            tc_r <= tc_nxt;
        end
    end
    assign test_thresh_o = (ts_r == TS_THRESH);
    assign test_low_o = (ts_r == TS_LOW);

    // ------------------------------------------------------------
    // Per-input evaluation
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] agree;
    logic [NUM_IN-1:0] xs_bad;
    logic [NUM_IN-1:0] seen_r, seen_nxt;
    logic [NUM_IN-1:0] hold_r, hold_nxt;
    logic [2:0] ph_d_r;
    logic testing;

    assign testing = (ts_r != TS_IDLE);
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic exp;
            assign agree[gi] = ch_a[gi] & ch_b[gi]; // [RQ1] [RQ2]
            // Assigned pulse level as seen behind the synchroniser
            assign exp = psel_r[gi] ? SIG_SECOND[ph_d_r - 3'h1] :
                SIG_FIRST[ph_d_r - 3'h1];
            // Checked only while either channel High and pulse assigned
            assign xs_bad[gi] = xs_en_r[gi] && !testing &&
                (ch_a[gi] | ch_b[gi]) && !exp; // [RQ6] [RQ7] [RQ8] [RQ15]
        end
    endgenerate

    // Start test bookkeeping and signature held per input
    always_comb begin
        // Injected Low of the cyclic test does not count
        seen_nxt = seen_r | (~(ch_a | ch_b) &
            {NUM_IN{!testing && tc_r >= TST_W'(SETTLE_CYC)}}); // [RQ14]
        hold_nxt = hold_r | xs_bad;
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            seen_r <= '0;
            hold_r <= '0;
            ph_d_r <= 3'h0;
        end else begin
            seen_r <= seen_nxt;
            hold_r <= alarm_clr ? '0 : hold_nxt;
            ph_d_r <= phase;
        end
    end

    // ------------------------------------------------------------
    // Multi-contact pairs and time-out
    // ------------------------------------------------------------
    logic [CNT_W-1:0] toc_r [NUM_PAIR];
    logic [CNT_W-1:0] toc_nxt [NUM_PAIR];
    logic [NUM_PAIR-1:0] to_ev;
    logic [NUM_IN-1:0] comb_w;

    generate
        for (gi = 0; gi < NUM_PAIR; gi++) begin : g_pair
            logic c0, c1, ok, und;
            assign c0 = agree[2*gi];
            assign c1 = agree[2*gi+1];
            always_comb begin
                ok = c0 & c1; // [RQ9] [RQ10]
                und = c0 ^ c1;
                if (pmode_r[2*gi+:2] == PM_NO_NC) begin
                    ok = c0 & ~c1; // [RQ11]
                    und = c0 & c1;
                end
            end
            assign comb_w[2*gi] = (pmode_r[2*gi+:2] == PM_SINGLE) ? c0 : ok;
            assign comb_w[2*gi+1] =
                (pmode_r[2*gi+:2] == PM_SINGLE) ? c1 : ok;
            // Count time spent in an undefined combination
            always_comb begin
                toc_nxt[gi] = '0;
                if (to_en_r[gi] && und &&
                    pmode_r[2*gi+:2] != PM_SINGLE) begin // [RQ12]
                    toc_nxt[gi] = toc_r[gi];
                    if (toc_r[gi] <= CNT_W'(TIMEOUT_CYCLES)) begin
                        toc_nxt[gi] = toc_r[gi] + 24'h1;
                    end
                end
            end
            assign to_ev[gi] =
                (toc_r[gi] == CNT_W'(TIMEOUT_CYCLES)); // [RQ13]
            always_ff @(posedge clk_sys_i or posedge reset_i) begin
                if (reset_i) begin
                    toc_r[gi] <= '0;
                end else begin
                    toc_r[gi] <= toc_nxt[gi];
                end
            end
        end
    endgenerate

    assign ev = {|to_ev, |xs_bad, low_fail, thr_fail};
    // Held Low on alarm, cross-short, or missing start test
    assign safe_w = comb_w & ~hold_r & (seen_r | ~st_en_r) &
        {NUM_IN{~alarm_r}}; // [RQ14] [RQ16]

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] safe_r;
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            safe_r <= '0;
        end else begin
            safe_r <= testing ? safe_r : safe_w;
        end
    end
    assign safe_state_o = safe_r;
    assign alarm_o = alarm_r;
    assign irq_o = irq_r;
    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign pulse_output_first_o = p1;
    assign pulse_output_second_o = p2;
endmodule
`default_nettype wire

// ===== verification/sid_chk.sv
// Port checker for the safety input diagnostics block
`timescale 1ns/1ps
`default_nettype none
module sid_chk
    import sid_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = 50
) (
    // Clock, reset and bus handshake
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // Field side and results
    input wire logic [NUM_IN-1:0] in_ch_a_i,
    input wire logic [NUM_IN-1:0] in_ch_b_i,
    input wire logic [1:0] thresh_ok_i,
    input wire logic test_low_o,
    input wire logic test_thresh_o,
    input wire logic pulse_output_first_o,
    input wire logic pulse_output_second_o,
    input wire logic [NUM_IN-1:0] safe_state_o,
    input wire logic alarm_o
);
    default clocking cb_sys @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // Both channels high, per input
    wire logic [NUM_IN-1:0] both_hi;
    assign both_hi = in_ch_a_i & in_ch_b_i;

    // --------------------------------------------------------
    // Cycles since reset, saturating
    // --------------------------------------------------------
    logic [3:0] run_r;
    logic [3:0] run_nxt;
    always_comb begin
        run_nxt = (run_r == 4'hf) ? run_r : run_r + 4'h1;
    end
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            run_r <= 4'h0;
        end else begin
            run_r <= run_nxt;
        end
    end

    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    property p_wait_ans;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_wait_ans: assert property (p_wait_ans)
        else $error("bus request not answered");
    property p_wait_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("waitrequest low too long");
    property p_pair_rise;
        (safe_state_o & ~$past(safe_state_o) & ~($past(both_hi, 2)
            | $past(both_hi, 3) | $past(both_hi, 4))) == '0;
    endproperty
    a_pair_rise: assert property (p_pair_rise)
        else $error("input high without both channels high");
    property p_low_len;
        $rose(test_low_o) |-> test_low_o [*4] ##1 !test_low_o;
    endproperty
    a_low_len: assert property (p_low_len)
        else $error("low injection length wrong");
    property p_thr_len;
        $rose(test_thresh_o) |-> test_thresh_o [*4] ##1 !test_thresh_o;
    endproperty
    a_thr_len: assert property (p_thr_len)
        else $error("threshold test length wrong");
    property p_pulse_rep;
        run_r == 4'hf |-> pulse_output_first_o == $past(pulse_output_first_o, 8)
            && pulse_output_second_o != pulse_output_first_o;
    endproperty
    a_pulse_rep: assert property (p_pulse_rep)
        else $error("pulse signatures wrong");
    property p_alarm_hold;
        alarm_o && !avs_write_i && !$past(avs_write_i) |=> alarm_o;
    endproperty
    a_alarm_hold: assert property (p_alarm_hold)
        else $error("alarm dropped without clear");
    property p_thr_alarm;
        $fell(test_thresh_o) && thresh_ok_i != 2'h3
            && $past(thresh_ok_i, 6) != 2'h3 |-> ##[0:6] alarm_o;
    endproperty
    a_thr_alarm: assert property (p_thr_alarm)
        else $error("bad threshold gave no alarm");
endmodule
`default_nettype wire

// ===== verification/sid_field_model.sv
// Behavioural model of the contacts and sensors at the field inputs
`timescale 1ns/1ps
`default_nettype none
module sid_field_model
    import sid_pkg::*;
(
    // Test injection and pulse supply from the block
    input wire logic test_low_i,
    input wire logic pulse_first_i,
    input wire logic pulse_second_i,
    // Contact levels and faults commanded by the bench
    input wire logic [NUM_IN-1:0] cont_a_i,
    input wire logic [NUM_IN-1:0] cont_b_i,
    input wire logic [NUM_IN-1:0] stuck_i,
    input wire logic [NUM_IN-1:0] fed_i,
    input wire logic thr_bad_i,
    // Levels seen at the block's pins
    output logic [NUM_IN-1:0] in_ch_a_o,
    output logic [NUM_IN-1:0] in_ch_b_o,
    output logic [1:0] thresh_ok_o
);
    logic [NUM_IN-1:0] sup;
    logic [NUM_IN-1:0] low;
    // Supply, low pull and comparator answer
    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            // Alternating pulse feed on fed contacts
            sup[i] = !fed_i[i] || (i % 2 ? pulse_second_i : pulse_first_i);
        end
        low = test_low_i ? ~PULSE_ONLY_INPUT_GROUP & ~stuck_i : '0;
        in_ch_a_o = cont_a_i & sup & ~low;
        in_ch_b_o = cont_b_i & sup & ~low;
        thresh_ok_o = thr_bad_i ? 2'h1 : 2'h3;
    end
endmodule
`default_nettype wire

// ===== verification/sid_top_tb_top.sv
// Self-checking bench for the safety input diagnostics block
`timescale 1ns/1ps
`default_nettype none
module sid_top_tb_top
    import sid_pkg::*;
;
    localparam int TO_CYC = 50;
    localparam logic RD = 1'b0;
    localparam logic WR = 1'b1;
    logic clk_sys_i;
    logic reset_i = 1'b1;
    logic [5:0] avs_address_i = 6'h0;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_waitrequest_o;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdv;
    logic [NUM_IN-1:0] in_ch_a_i, in_ch_b_i, safe_state_o;
    logic [1:0] thresh_ok_i;
    logic test_low_o, test_thresh_o, alarm_o, irq_o, thr_bad = 1'b0;
    logic pulse_output_first_o, pulse_output_second_o;
    logic [NUM_IN-1:0] ca = 8'h20, cb = 8'h20, stuck = 8'h0, fed = 8'h0;
    logic [NUM_IN-1:0] st_blk = 8'h0;
    int pm[NUM_PAIR] = '{0, 0, 0, 0};
    int errors = 0, checks_done = 0;
    logic [31:0] r;

    // Design and far side
    sid_top #(.TIMEOUT_CYCLES(TO_CYC)) uut (
        .clk_sys_i, .reset_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
        .in_ch_a_i, .in_ch_b_i, .thresh_ok_i, .test_low_o, .test_thresh_o,
        .pulse_output_first_o, .pulse_output_second_o, .safe_state_o,
        .alarm_o, .irq_o);
    sid_field_model u_field (
        .test_low_i(test_low_o), .pulse_first_i(pulse_output_first_o),
        .pulse_second_i(pulse_output_second_o), .cont_a_i(ca),
        .cont_b_i(cb), .stuck_i(stuck), .fed_i(fed), .thr_bad_i(thr_bad),
        .in_ch_a_o(in_ch_a_i), .in_ch_b_o(in_ch_b_i),
        .thresh_ok_o(thresh_ok_i));

    // Clock, 100 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // Tasks and reference model
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n == 50) errors++;
        rdv = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    function automatic logic [NUM_IN-1:0] model_safe();
        logic [NUM_IN-1:0] e;
        logic ok;
        e = ca & cb & ~st_blk;
        for (int k = 0; k < NUM_PAIR; k++) begin
            ok = pm[k] == 2 ? e[2*k] && !e[2*k+1] : e[2*k] && e[2*k+1];
            if (pm[k] != 0) begin
                e[2*k] = ok;
                e[2*k+1] = ok;
            end
        end
        return e;
    endfunction
    task automatic set_c(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_sys_i);
        ca <= a;
        cb <= b;
        st_blk = st_blk & a & b;
    endtask
    task automatic wait_quiet();
        int q;
        q = 0;
        for (int n = 0; n < 1000 && q < 8; n++) begin
            @(posedge clk_sys_i);
            q = (test_low_o || test_thresh_o) ? 0 : q + 1;
        end
    endtask
    task automatic chk_safe();
        wait_quiet();
        chk("safe", 32'(model_safe()), 32'(safe_state_o));
    endtask
    task automatic wait_alarm(input int b);
        logic i0;
        for (int n = 0; n < 2000 && alarm_o !== 1'b1; n++) begin
            @(posedge clk_sys_i);
        end
        chk("alarm", 32'h1, 32'(alarm_o));
        bus(RD, A_IRQ_STAT, 32'h0);
        chk("status", 32'h1, 32'(rdv[b]));
        bus(WR, A_IRQ_MASK, 32'h0);
        repeat (3) @(posedge clk_sys_i);
        i0 = irq_o;
        bus(WR, A_IRQ_MASK, 32'hf);
        repeat (3) @(posedge clk_sys_i);
        chk("irq_mask", 32'h1, 32'(i0 ^ irq_o));
    endtask
    task automatic clr();
        wait_quiet();
        bus(WR, A_ALARM_CLR, 32'h1);
        bus(WR, A_IRQ_STAT, 32'hf);
        bus(RD, A_IRQ_STAT, 32'h0);
        chk("status", 32'h0, rdv);
        chk("alarm", 32'h0, 32'(alarm_o));
        chk("irq", 32'h0, 32'(irq_o));
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(27));
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int a = 0; a <= 32; a += 4) begin
            bus(RD, 6'(a), 32'h0);
            chk("reg", 6'(a) == A_STATE ? 32'(model_safe()) : 32'h0, rdv);
        end
        bus(WR, 6'h3c, 32'hffff_ffff);
        bus(RD, 6'h3c, 32'h0);
        chk("unmapped", 32'h0, rdv);
        bus(WR, A_START_EN, 32'h20);
        st_blk = 8'h20;
        chk_safe();
        set_c(8'h00, 8'h00);
        set_c(8'h20, 8'h20);
        chk_safe();
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            set_c(r[7:0], r[7:0] ^ (r[15:8] & r[23:16]));
            chk_safe();
        end
        for (int m = 1; m < 3; m++) begin
            bus(WR, A_PAIR_MODE, m == 1 ? 32'h55 : 32'haa);
            pm = '{m, m, m, m};
            set_c(8'hff, 8'hff);
            chk_safe();
            set_c(8'hfd, 8'hfe);
            chk_safe();
        end
        bus(WR, A_PAIR_MODE, 32'h0);
        pm = '{0, 0, 0, 0};
        set_c(8'h10, 8'h10);
        stuck <= 8'h10;
        repeat (600) @(posedge clk_sys_i);
        chk("alarm", 32'h0, 32'(alarm_o));
        stuck <= 8'h01;
        set_c(8'h11, 8'h11);
        wait_alarm(ST_LOWTEST);
        stuck <= 8'h00;
        clr();
        thr_bad <= 1'b1;
        wait_alarm(ST_THRESH);
        thr_bad <= 1'b0;
        clr();
        bus(WR, A_PAIR_MODE, 32'h04);
        pm[1] = 1;
        bus(WR, A_TO_EN, 32'h2);
        set_c(8'h04, 8'h04);
        repeat (TO_CYC / 2) @(posedge clk_sys_i);
        set_c(8'h0c, 8'h0c);
        repeat (400) @(posedge clk_sys_i);
        chk("alarm", 32'h0, 32'(alarm_o));
        chk_safe();
        set_c(8'h04, 8'h04);
        wait_alarm(ST_TIMEOUT);
        set_c(8'h00, 8'h00);
        clr();
        bus(WR, A_XS_EN, 32'h08);
        fed <= 8'h08;
        set_c(8'h08, 8'h08);
        wait_alarm(ST_XSHORT);
        bus(WR, A_XS_EN, 32'h0);
        fed <= 8'h00;
        set_c(8'h00, 8'h00);
        clr();
        print_verdict();
    end
endmodule

bind sid_top sid_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .clk_sys_i, .reset_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o,
    .in_ch_a_i, .in_ch_b_i, .thresh_ok_i, .test_low_o, .test_thresh_o,
    .pulse_output_first_o, .pulse_output_second_o, .safe_state_o,
    .alarm_o);
`default_nettype wire
